//--- core/serial_link_pkg.sv
// shared constants, register map and helpers for the serial link transmit control
package serial_link_pkg;
  localparam int ADC_W = 9;
  localparam int LINK_N = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ADDR_W = 10;
  localparam int K_W = 9;

  localparam logic [ADDR_W-1:0] SAMPLE_LSB_CONTROL_OFS = 10'h160;
  localparam logic [ADDR_W-1:0] SERIAL_LINK_ENABLE_OFS = 10'h200;
  localparam logic [ADDR_W-1:0] LINK_OUTPUT_MODE_OFS = 10'h201;
  localparam logic [ADDR_W-1:0] K_MINUS_ONE_OFS = 10'h202;
  localparam logic [ADDR_W-1:0] MANUAL_SYNC_OFS = 10'h203;
  localparam logic [ADDR_W-1:0] LINK_STATUS_OFS = 10'h208;
  localparam logic [ADDR_W-1:0] CAL_ENABLE_OFS = 10'h209;
  localparam logic [ADDR_W-1:0] TS_RECEIVER_OFS = 10'h20a;

  localparam logic [7:0] SAMPLE_LSB_CONTROL_RST = 8'h00;
  localparam logic [7:0] SERIAL_LINK_ENABLE_RST = 8'h01;
  localparam logic [7:0] LINK_OUTPUT_MODE_RST = 8'h00;
  localparam logic [7:0] K_MINUS_ONE_RST = 8'h1f;
  localparam logic [7:0] MANUAL_SYNC_RST = 8'h01;
  localparam logic [7:0] CAL_ENABLE_RST = 8'h00;
  localparam logic [7:0] TS_RECEIVER_RST = 8'h00;
  localparam logic [7:0] REG_ZERO = 8'h00;

  localparam int BIT_ENABLE = 0;
  localparam int MODE_W = 6;
  localparam logic [MODE_W-1:0] MODE_64B_FIRST = 6'h10;
  localparam logic [K_W-1:0] K_64B_BASE = 9'h100;
  localparam logic [1:0] ILA_CS_VALUE = 2'h0;

  function automatic logic uses64b66b(input logic [MODE_W-1:0] mode);
    return mode >= MODE_64B_FIRST;
  endfunction

  // effective frames per multiframe; 64b/66b modes take 256*E/F with E=1, F=2^mode[1:0]
  function automatic logic [K_W-1:0] effectiveK(input logic [MODE_W-1:0] mode,
                                                input logic [7:0] kMinusOne);
    if (uses64b66b(mode)) begin
      return K_64B_BASE >> mode[1:0];
    end
    return {1'b0, kMinusOne} + 9'h001;
  endfunction
endpackage

//--- core/serial_link_if.sv
// register port and sample link between the host end and the converter end
`timescale 1ns/1ps
interface serial_link_if;
  import serial_link_pkg::*;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regWdata;
  logic regWrite;
  logic regRead;
  logic [7:0] regRdata;
  logic regRdValid;
  logic [LINK_N-1:0] linkData;
  logic linkMfStart;
  logic linkValid;
  logic linkReady;
  logic [1:0] ilaCs;
  logic [K_W-1:0] ilaK;
  logic [MODE_W-1:0] ilaMode;
  logic syncPinN;
  logic sysref;

  modport dev (input regAddr, regWdata, regWrite, regRead, linkReady, syncPinN, sysref,
               output regRdata, regRdValid, linkData, linkMfStart, linkValid, ilaCs, ilaK,
               ilaMode);
  modport host (output regAddr, regWdata, regWrite, regRead, linkReady, syncPinN, sysref,
                input regRdata, regRdValid, linkData, linkMfStart, linkValid, ilaCs, ilaK,
                ilaMode);
endinterface

//--- core/sample_fifo.sv
// small synchronous fifo with valid/ready on both sides and a flush
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_param_check
    $error("sample_fifo: depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [PW:0] count;
  } state_t;

  state_t s_r, s_nxt;
  logic doPush, doPop;

  assign inReady = s_r.count != (PW+1)'(DEPTH);
  assign outValid = s_r.count != '0;
  assign outData = s_r.mem[s_r.rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_comb begin
    s_nxt = s_r;
    if (flush) begin
      s_nxt.wrPtr = '0;
      s_nxt.rdPtr = '0;
      s_nxt.count = '0;
    end else begin
      if (doPush) begin
        s_nxt.mem[s_r.wrPtr] = inData;
        s_nxt.wrPtr = s_r.wrPtr + 1'b1;
      end
      if (doPop) begin
        s_nxt.rdPtr = s_r.rdPtr + 1'b1;
      end
      s_nxt.count = s_r.count + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule // sample_fifo

//--- core/serial_link_tx.sv
// converter end: link control registers, timestamp insertion and multiframe timing
// Summary of operation
// - timestamp enable puts timestamp on sample LSB
// - LSB of N-bit field; keep converter LSB
// - lane alignment always advertises zero control bits
// - timestamp latency equals sample path latency
// - software enables timestamp receiver with insertion
// - link enable bit 0, resets to 1
// - disabled: reset, serializers down, clocks gated
// - disabled: multiframe counter reset, ignores SYSREF
// - software clears link enable before reconfiguring
// - calibration enable set before link enable
// - link enable cleared before calibration enable
// - mode field 5:0, changed only both disabled
// - K register holds K-1, default 32
// - software picks K legal for mode
// - 64b/66b modes use K = 256*E/F
// - K changed only while link disabled
// - reserved bits written with reset value
// - manual sync bit low requests synchronization
`timescale 1ns/1ps
module serial_link_tx (
  input wire logic ref_clk,
  input wire logic rst_b,
  serial_link_if.dev link,
  input wire logic [serial_link_pkg::ADC_W-1:0] adcSample,
  input wire logic timestampIn,
  input wire logic sampleValid,
  output logic sampleReady,
  output logic serPowerDown,
  output logic linkClkEn,
  output logic linkInReset,
  output logic syncRequest,
  output logic timestampRecvEn,
  output logic calEnable
);
  import serial_link_pkg::*;

  localparam int WORD_W = ADC_W + 1;
  localparam int FILL_W = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic tsOnLsb;
    logic linkEn;
    logic [MODE_W-1:0] mode;
    logic [7:0] kMinusOne;
    logic manualSyncN;
    logic calEn;
    logic tsRecvEn;
    logic [7:0] rdData;
    logic rdValid;
    logic sysrefMeta;
    logic sysrefSync;
    logic sysrefPrev;
    logic syncMeta;
    logic syncSync;
    logic [LINK_N-1:0] linkData;
    logic linkValid;
    logic mfStart;
    logic [K_W-1:0] mfCount;
    logic [K_W-1:0] kEff;
    logic syncReq;
    logic serPd;
    logic clkEn;
    logic subsysRst;
    logic sampleRdy;
    logic [FILL_W-1:0] fill;
  } state_t;

  state_t s_r, s_nxt;
  logic fifoValid, fifoPop, fifoInReady, fifoPush;
  logic [WORD_W-1:0] fifoData;

  function automatic logic [LINK_N-1:0] packSample(input logic [ADC_W-1:0] smp,
                                                   input logic ts, input logic tsOn);
    logic [LINK_N-1:0] w;
    w = {smp, {(LINK_N-ADC_W){1'b0}}};
    if (tsOn) begin
      w[0] = ts;
    end
    return w;
  endfunction

  if (LINK_N < ADC_W) begin : g_width_check
    $error("serial_link_tx: link sample narrower than converter sample");
  end

  // sample and timestamp share one fifo word, so both see identical latency
  sample_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .flush(s_r.subsysRst),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData({adcSample, timestampIn}),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign fifoPop = fifoValid && s_r.linkEn && !s_r.subsysRst
                   && (!s_r.linkValid || link.linkReady);
  assign fifoPush = sampleValid && s_r.sampleRdy;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdValid = 1'b0;
    // pins from the far party cross into this clock through two flops
    s_nxt.sysrefMeta = link.sysref;
    s_nxt.sysrefSync = s_r.sysrefMeta;
    s_nxt.sysrefPrev = s_r.sysrefSync;
    s_nxt.syncMeta = link.syncPinN;
    s_nxt.syncSync = s_r.syncMeta;

    if (link.regWrite) begin
      case (link.regAddr)
        SAMPLE_LSB_CONTROL_OFS: s_nxt.tsOnLsb = link.regWdata[BIT_ENABLE];
        SERIAL_LINK_ENABLE_OFS: s_nxt.linkEn = link.regWdata[BIT_ENABLE];
        LINK_OUTPUT_MODE_OFS: begin
          // a late mode change would corrupt a running link, so it is dropped
          if (!s_r.linkEn && !s_r.calEn) begin
            s_nxt.mode = link.regWdata[MODE_W-1:0];
          end
        end
        K_MINUS_ONE_OFS: begin
          if (!s_r.linkEn) begin
            s_nxt.kMinusOne = link.regWdata;
          end
        end
        MANUAL_SYNC_OFS: s_nxt.manualSyncN = link.regWdata[BIT_ENABLE];
        CAL_ENABLE_OFS: s_nxt.calEn = link.regWdata[BIT_ENABLE];
        TS_RECEIVER_OFS: s_nxt.tsRecvEn = link.regWdata[BIT_ENABLE];
        default: ;
      endcase
    end

    if (link.regRead) begin
      s_nxt.rdValid = 1'b1;
      // reserved bits are not stored and read back as zero
      case (link.regAddr)
        SAMPLE_LSB_CONTROL_OFS: s_nxt.rdData = {7'h00, s_r.tsOnLsb};
        SERIAL_LINK_ENABLE_OFS: s_nxt.rdData = {7'h00, s_r.linkEn};
        LINK_OUTPUT_MODE_OFS: s_nxt.rdData = {2'h0, s_r.mode};
        K_MINUS_ONE_OFS: s_nxt.rdData = s_r.kMinusOne;
        MANUAL_SYNC_OFS: s_nxt.rdData = {7'h00, s_r.manualSyncN};
        CAL_ENABLE_OFS: s_nxt.rdData = {7'h00, s_r.calEn};
        TS_RECEIVER_OFS: s_nxt.rdData = {7'h00, s_r.tsRecvEn};
        LINK_STATUS_OFS: s_nxt.rdData = {4'h0, s_r.mfStart, s_r.linkValid, s_r.syncReq,
                                         !s_r.subsysRst};
        default: s_nxt.rdData = REG_ZERO;
      endcase
    end

    s_nxt.subsysRst = !s_r.linkEn;
    s_nxt.serPd = !s_r.linkEn;
    s_nxt.clkEn = s_r.linkEn;
    s_nxt.kEff = effectiveK(s_r.mode, s_r.kMinusOne);
    s_nxt.syncReq = s_r.linkEn && (!s_r.manualSyncN || !s_r.syncSync);
    // ready is registered, so it must foresee the fifo level after this edge
    s_nxt.fill = s_r.fill + FILL_W'(fifoPush && fifoInReady) - FILL_W'(fifoPop);
    s_nxt.sampleRdy = s_r.linkEn && s_nxt.fill != FILL_W'(FIFO_DEPTH);

    if (s_r.subsysRst) begin
      s_nxt.linkValid = 1'b0;
      s_nxt.mfStart = 1'b0;
      s_nxt.mfCount = '0;
      s_nxt.sampleRdy = 1'b0;
      s_nxt.fill = '0;
    end else begin
      if (link.linkReady) begin
        s_nxt.linkValid = 1'b0;
      end
      if (fifoPop) begin
        s_nxt.linkData = packSample(fifoData[WORD_W-1:1], fifoData[0], s_r.tsOnLsb);
        s_nxt.linkValid = 1'b1;
        s_nxt.mfStart = s_r.mfCount == '0;
        s_nxt.mfCount = (s_r.mfCount >= s_r.kEff - 9'h001) ? '0 : s_r.mfCount + 9'h001;
      end
      // sysref aligns the counter only while the subsystem runs
      if (s_r.sysrefSync && !s_r.sysrefPrev) begin
        s_nxt.mfCount = '0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.tsOnLsb <= SAMPLE_LSB_CONTROL_RST[BIT_ENABLE];
      s_r.linkEn <= SERIAL_LINK_ENABLE_RST[BIT_ENABLE];
      s_r.mode <= LINK_OUTPUT_MODE_RST[MODE_W-1:0];
      s_r.kMinusOne <= K_MINUS_ONE_RST;
      s_r.manualSyncN <= MANUAL_SYNC_RST[BIT_ENABLE];
      s_r.calEn <= CAL_ENABLE_RST[BIT_ENABLE];
      s_r.tsRecvEn <= TS_RECEIVER_RST[BIT_ENABLE];
      s_r.sysrefMeta <= 1'b0;
      s_r.syncMeta <= 1'b1;
      s_r.syncSync <= 1'b1;
      s_r.subsysRst <= 1'b1;
      s_r.serPd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.regRdata = s_r.rdData;
  assign link.regRdValid = s_r.rdValid;
  assign link.linkData = s_r.linkData;
  assign link.linkMfStart = s_r.mfStart;
  assign link.linkValid = s_r.linkValid;
  assign link.ilaCs = ILA_CS_VALUE;
  assign link.ilaK = s_r.kEff;
  assign link.ilaMode = s_r.mode;
  assign sampleReady = s_r.sampleRdy;
  assign serPowerDown = s_r.serPd;
  assign linkClkEn = s_r.clkEn;
  assign linkInReset = s_r.subsysRst;
  assign syncRequest = s_r.syncReq;
  assign timestampRecvEn = s_r.tsRecvEn;
  assign calEnable = s_r.calEn;
endmodule // serial_link_tx

//--- core/serial_link_rx_host.sv
// host end: ordered configuration writes, register reads and sample reception
`timescale 1ns/1ps
module serial_link_rx_host (
  input wire logic ref_clk,
  input wire logic rst_b,
  serial_link_if.host link,
  input wire logic cfgStart,
  input wire logic cfgStop,
  input wire logic [serial_link_pkg::MODE_W-1:0] cfgMode,
  input wire logic [7:0] cfgKMinusOne,
  input wire logic cfgTimestamp,
  output logic cfgBusy,
  input wire logic rdReq,
  input wire logic [serial_link_pkg::ADDR_W-1:0] rdAddr,
  output logic [7:0] rdData,
  output logic rdDone,
  input wire logic syncReqIn,
  input wire logic sysrefIn,
  output logic [serial_link_pkg::LINK_N-1:0] rxData,
  output logic rxMfStart,
  output logic rxValid,
  input wire logic rxReady
);
  import serial_link_pkg::*;

  typedef enum logic [1:0] {IDLE, WRITING} phase_t;

  typedef struct packed {
    phase_t phase;
    logic [2:0] step;
    logic [2:0] lastStep;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdData;
    logic rdDone;
    logic syncN;
    logic sysref;
    logic [LINK_N-1:0] rxData;
    logic rxMfStart;
    logic rxValid;
  } state_t;

  state_t s_r, s_nxt;

  // link off, cal off, mode, K, receiver, lsb control, cal on, link on
  function automatic logic [ADDR_W+7:0] stepWrite(input logic [2:0] idx);
    case (idx)
      3'h0: return {SERIAL_LINK_ENABLE_OFS, REG_ZERO};
      3'h1: return {CAL_ENABLE_OFS, REG_ZERO};
      3'h2: return {LINK_OUTPUT_MODE_OFS, 2'h0, cfgMode};
      3'h3: return {K_MINUS_ONE_OFS, cfgKMinusOne};
      3'h4: return {TS_RECEIVER_OFS, 7'h00, cfgTimestamp};
      3'h5: return {SAMPLE_LSB_CONTROL_OFS, 7'h00, cfgTimestamp};
      3'h6: return {CAL_ENABLE_OFS, SERIAL_LINK_ENABLE_RST};
      default: return {SERIAL_LINK_ENABLE_OFS, SERIAL_LINK_ENABLE_RST};
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    s_nxt.rdDone = 1'b0;
    s_nxt.syncN = !syncReqIn;
    s_nxt.sysref = sysrefIn;
    case (s_r.phase)
      IDLE: begin
        if (cfgStart || cfgStop) begin
          s_nxt.phase = WRITING;
          s_nxt.step = 3'h0;
          s_nxt.lastStep = cfgStart ? 3'h7 : 3'h1;
        end else if (rdReq) begin
          s_nxt.addr = rdAddr;
          s_nxt.rd = 1'b1;
        end
      end
      WRITING: begin
        {s_nxt.addr, s_nxt.wdata} = stepWrite(s_r.step);
        s_nxt.wr = 1'b1;
        s_nxt.step = s_r.step + 3'h1;
        if (s_r.step == s_r.lastStep) begin
          s_nxt.phase = IDLE;
        end
      end
      default: s_nxt.phase = IDLE;
    endcase
    if (link.regRdValid) begin
      s_nxt.rdData = link.regRdata;
      s_nxt.rdDone = 1'b1;
    end
    if (rxReady) begin
      s_nxt.rxValid = 1'b0;
    end
    if (link.linkValid && (!s_r.rxValid || rxReady)) begin
      s_nxt.rxData = link.linkData;
      s_nxt.rxMfStart = link.linkMfStart;
      s_nxt.rxValid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.phase <= IDLE;
      s_r.syncN <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.regAddr = s_r.addr;
  assign link.regWdata = s_r.wdata;
  assign link.regWrite = s_r.wr;
  assign link.regRead = s_r.rd;
  assign link.linkReady = !s_r.rxValid || rxReady;
  assign link.syncPinN = s_r.syncN;
  assign link.sysref = s_r.sysref;
  assign cfgBusy = s_r.phase != IDLE;
  assign rdData = s_r.rdData;
  assign rdDone = s_r.rdDone;
  assign rxData = s_r.rxData;
  assign rxMfStart = s_r.rxMfStart;
  assign rxValid = s_r.rxValid;
endmodule // serial_link_rx_host

//--- verif/serial_link_asserts.sv
// concurrent checks on the link between the host end and the converter end
`timescale 1ns/1ps
module serial_link_asserts (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [serial_link_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic regRdValid,
  input wire logic [serial_link_pkg::LINK_N-1:0] linkData,
  input wire logic linkMfStart,
  input wire logic linkValid,
  input wire logic linkReady,
  input wire logic [1:0] ilaCs,
  input wire logic [serial_link_pkg::K_W-1:0] ilaK,
  input wire logic [serial_link_pkg::MODE_W-1:0] ilaMode
);
  import serial_link_pkg::*;
  // shadow of the writes the device must accept, from the port traffic alone
  logic enR, calR, tsR, enPrev;
  logic [7:0] kR, modeR;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      enR <= 1'b1;
      calR <= 1'b0;
      tsR <= 1'b0;
      enPrev <= 1'b1;
      kR <= 8'h1f;
      modeR <= 8'h00;
    end else begin
      enPrev <= enR;
      if (regWrite && regAddr == SERIAL_LINK_ENABLE_OFS) enR <= regWdata[0];
      if (regWrite && regAddr == CAL_ENABLE_OFS) calR <= regWdata[0];
      if (regWrite && regAddr == SAMPLE_LSB_CONTROL_OFS) tsR <= regWdata[0];
      if (regWrite && regAddr == K_MINUS_ONE_OFS && !enR) kR <= regWdata;
      if (regWrite && regAddr == LINK_OUTPUT_MODE_OFS && !enR && !calR) modeR <= regWdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_csZero;
    ilaCs == ILA_CS_VALUE;
  endproperty
  property p_enRead;
    regRead && !regWrite && regAddr == SERIAL_LINK_ENABLE_OFS |=>
      regRdValid && regRdata == {7'h00, enR};
  endproperty
  property p_padZero;
    linkValid |-> linkData[6:1] == 6'h00;
  endproperty
  // one edge of grace: the flush lands on the edge after the disabling write
  property p_offQuiet;
    !enR && !enPrev |-> !linkValid;
  endproperty
  property p_noTs;
    linkValid && !tsR |-> !linkData[0];
  endproperty
  property p_k8b;
    (ilaMode < MODE_64B_FIRST && $stable(kR))[*3] |-> ilaK == {1'b0, kR} + 9'h001;
  endproperty
  property p_k64;
    (ilaMode >= MODE_64B_FIRST)[*3] |-> ilaK == (9'h100 >> ilaMode[1:0]);
  endproperty
  property p_mode;
    ($stable(modeR))[*3] |-> ilaMode == modeR[5:0];
  endproperty
  a_csZero: assert property (p_csZero) else $error("control bit count not zero");
  a_enRead: assert property (p_enRead) else $error("enable readback wrong");
  a_padZero: assert property (p_padZero) else $error("pad bits not zero");
  a_offQuiet: assert property (p_offQuiet) else $error("link word while disabled");
  a_noTs: assert property (p_noTs) else $error("lsb set without timestamp");
  a_k8b: assert property (p_k8b) else $error("effective K not K-1 plus one");
  a_k64: assert property (p_k64) else $error("64b66b effective K wrong");
  a_mode: assert property (p_mode) else $error("mode differs from accepted write");
  c_mf: cover property (linkValid && linkReady && linkMfStart);
  c_ts: cover property (linkValid && linkData[0]);
  c_rd: cover property (regRdValid);
endmodule // serial_link_asserts

//--- verif/testbench.sv
// self-checking bench joining the host end and the converter end
`timescale 1ns/1ps
module testbench;
  import serial_link_pkg::*;
  logic ref_clk = 1'b0, rst_b = 1'b0;
  logic [ADC_W-1:0] adcSample = 9'h000;
  logic timestampIn = 1'b0, sampleValid = 1'b0, cfgStart = 1'b0, cfgStop = 1'b0;
  logic [MODE_W-1:0] cfgMode = 6'h00;
  logic [7:0] cfgKMinusOne = 8'h00;
  logic cfgTimestamp = 1'b0, rdReq = 1'b0, syncReqIn = 1'b0, sysrefIn = 1'b0, rxReady = 1'b1;
  logic [ADDR_W-1:0] rdAddr = 10'h000;
  logic sampleReady, serPowerDown, linkClkEn, linkInReset, syncRequest;
  logic timestampRecvEn, calEnable, cfgBusy, rdDone, rxMfStart, rxValid;
  logic [7:0] rdData;
  logic [LINK_N-1:0] rxData;
  logic [16:0] got[$];
  int errors = 0, nTests = 0;
  serial_link_if link();
  serial_link_tx u_serial_link_tx (.ref_clk, .rst_b, .link, .adcSample, .timestampIn,
    .sampleValid, .sampleReady, .serPowerDown, .linkClkEn, .linkInReset, .syncRequest,
    .timestampRecvEn, .calEnable);
  serial_link_rx_host u_serial_link_rx_host (.ref_clk, .rst_b, .link, .cfgStart, .cfgStop,
    .cfgMode, .cfgKMinusOne, .cfgTimestamp, .cfgBusy, .rdReq, .rdAddr, .rdData, .rdDone,
    .syncReqIn, .sysrefIn, .rxData, .rxMfStart, .rxValid, .rxReady);
  serial_link_asserts u_serial_link_asserts (.ref_clk, .rst_b, .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regWrite(link.regWrite), .regRead(link.regRead),
    .regRdata(link.regRdata), .regRdValid(link.regRdValid), .linkData(link.linkData),
    .linkMfStart(link.linkMfStart), .linkValid(link.linkValid), .linkReady(link.linkReady),
    .ilaCs(link.ilaCs), .ilaK(link.ilaK), .ilaMode(link.ilaMode));
  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
  // values read here are those before this edge's update: the word the host lets go
  always @(posedge ref_clk) begin
    if (rxValid === 1'b1 && rxReady === 1'b1) got.push_back({rxMfStart, rxData});
  end
  task automatic conclude;
    if (errors == 0 && nTests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle;
    int g = 0;
    while (cfgBusy !== 1'b0 && g < 40) begin
      @(negedge ref_clk);
      g++;
    end
    check(17'(cfgBusy), 17'h0);
  endtask
  task automatic configure(input logic [5:0] m, input logic [7:0] k, input logic ts);
    cfgMode = m;
    cfgKMinusOne = k;
    cfgTimestamp = ts;
    cfgStart = 1'b1;
    @(negedge ref_clk);
    cfgStart = 1'b0;
    idle();
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    int g = 0;
    rdAddr = a;
    rdReq = 1'b1;
    @(negedge ref_clk);
    rdReq = 1'b0;
    while (rdDone !== 1'b1 && g < 10) begin
      @(negedge ref_clk);
      g++;
    end
    check(17'(rdData), 17'(exp));
  endtask
  // sampleReady only moves on posedge, so its negedge value decides the next take
  task automatic send(input int n, input logic ts, input int k, input bit stall);
    int i = 0;
    int g = 0;
    got.delete();
    rxReady = !stall;
    while (i < n && g < 200) begin
      g++;
      if (sampleReady !== 1'b1 && stall) break;
      adcSample = 9'(i * 29 + 3);
      timestampIn = ts & i[0];
      sampleValid = 1'b1;
      if (sampleReady === 1'b1) i++;
      @(negedge ref_clk);
    end
    sampleValid = 1'b0;
    rxReady = 1'b1;
    if (stall) check(17'(i >= FIFO_DEPTH), 17'h1);
    repeat (24) @(negedge ref_clk);
    check(17'(got.size()), 17'(i));
    foreach (got[j]) check(got[j], {j % k == 0, 9'(j * 29 + 3), 6'h00, ts & j[0]});
  endtask
  initial begin
    #(CLK_PERIOD_NS * 8000);
    errors++;
    conclude();
  end
  initial begin
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    @(negedge ref_clk);
    rd(SAMPLE_LSB_CONTROL_OFS, 8'h00);
    rd(SERIAL_LINK_ENABLE_OFS, 8'h01);
    rd(LINK_OUTPUT_MODE_OFS, 8'h00);
    rd(K_MINUS_ONE_OFS, 8'h1f);
    rd(MANUAL_SYNC_OFS, 8'h01);
    rd(10'h3ff, 8'h00);
    check(17'({serPowerDown, linkClkEn, linkInReset}), 17'h2);
    configure(6'h00, 8'h03, 1'b1);
    rd(K_MINUS_ONE_OFS, 8'h03);
    rd(SAMPLE_LSB_CONTROL_OFS, 8'h01);
    check(17'({timestampRecvEn, calEnable}), 17'h3);
    check(17'(link.ilaK), 17'h4);
    send(30, 1'b1, 4, 1'b1);
    syncReqIn = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(17'(syncRequest), 17'h1);
    syncReqIn = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(17'(syncRequest), 17'h0);
    cfgStop = 1'b1;
    @(negedge ref_clk);
    cfgStop = 1'b0;
    idle();
    rd(SERIAL_LINK_ENABLE_OFS, 8'h00);
    check(17'({serPowerDown, linkClkEn, linkInReset, calEnable}), 17'ha);
    sampleValid = 1'b1;
    syncReqIn = 1'b1;
    sysrefIn = 1'b1;
    repeat (6) @(negedge ref_clk);
    check(17'({sampleReady, link.linkValid, syncRequest}), 17'h0);
    sampleValid = 1'b0;
    syncReqIn = 1'b0;
    sysrefIn = 1'b0;
    configure(6'h11, 8'h05, 1'b0);
    rd(K_MINUS_ONE_OFS, 8'h05);
    check(17'({link.ilaMode, link.ilaK}), 17'({6'h11, 9'h080}));
    send(6, 1'b0, 128, 1'b0);
    // counter now sits at 6; only a sysref can bring the next word back to frame 0
    sysrefIn = 1'b1;
    repeat (2) @(negedge ref_clk);
    sysrefIn = 1'b0;
    repeat (6) @(negedge ref_clk);
    send(6, 1'b0, 128, 1'b0);
    conclude();
  end
endmodule // testbench
